// [rtl/tpg_byte_pattern.sv]
// Byte stream of one active line: color bars or repeating fixed chunk
`timescale 1ns/1ps
`default_nettype none
`include "tpg_defs.svh"

module tpg_byte_pattern (
    input wire logic i_ref_clk, // System clock
    input wire logic i_rst, // Synchronous reset
    input wire logic i_line_start, // Active line begins
    input wire logic [15:0] i_line_size, // Bytes per active line
    input wire logic [15:0] i_bar_size, // Bytes per bar but the last
    input wire tpg_pkg::tpg_pattern_cfg_t i_cfg, // Pattern select byte
    input wire logic [14:0][7:0] i_colors, // Color bytes 0 to 14
    output logic o_valid, // Byte valid
    output logic [7:0] o_data // Pattern byte
);

    logic [15:0] remain_q;
    logic [15:0] bar_cnt_q;
    logic [2:0] bar_idx_q;
    logic [3:0] chunk_idx_q;
    logic [2:0] last_bar;
    logic [3:0] chunk_len;
    logic [7:0] color_now;

    always_comb
    begin
        last_bar = 3'h0;
        case (i_cfg.bar_count_code) // [R09]
            2'h0: last_bar = 3'h0;
            2'h1: last_bar = 3'h1;
            2'h2: last_bar = 3'h3;
            2'h3: last_bar = 3'h7;
            default: last_bar = 3'h0;
        endcase
        chunk_len = i_cfg.chunk_len; // [R10]
        if (chunk_len == 4'h0)
        begin
            chunk_len = 4'h1;
        end
        if (i_cfg.fixed_pattern_select) // [R08]
        begin
            color_now = i_colors[chunk_idx_q]; // [R06]
        end
        else
        begin
            color_now = i_colors[{1'b0, bar_idx_q}]; // [R05]
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            remain_q <= 16'h0000;
            bar_cnt_q <= 16'h0000;
            bar_idx_q <= 3'h0;
            chunk_idx_q <= 4'h0;
        end
        else if (i_line_start)
        begin
            remain_q <= i_line_size;
            bar_cnt_q <= 16'h0000;
            bar_idx_q <= 3'h0;
            chunk_idx_q <= 4'h0;
        end
        else if (remain_q != 16'h0000)
        begin
            remain_q <= remain_q - 16'h0001;
            // Last bar takes whatever bytes remain
            if (bar_cnt_q + 16'h0001 == i_bar_size && bar_idx_q < last_bar)
            begin
                bar_cnt_q <= 16'h0000;
                bar_idx_q <= bar_idx_q + 3'h1;
            end
            else
            begin
                bar_cnt_q <= bar_cnt_q + 16'h0001;
            end
            if (chunk_idx_q + 4'h1 >= chunk_len)
            begin
                chunk_idx_q <= 4'h0;
            end
            else
            begin
                chunk_idx_q <= chunk_idx_q + 4'h1;
            end
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_valid <= 1'b0;
            o_data <= 8'h00;
        end
        else
        begin
            o_valid <= (remain_q != 16'h0000) && !i_line_start;
            o_data <= color_now;
        end
    end

endmodule : tpg_byte_pattern
`default_nettype wire

// [rtl/tpg_defs.svh]
// Offsets, reset values and timing counts of the test-pattern timing slice
`ifndef TPG_DEFS_SVH
`define TPG_DEFS_SVH

// Indirect register page that holds the generator registers
`define TPG_PAGE 8'h00

// Register offsets within the page
`define TPG_OFS_LINE_PD_HI 8'h0C
`define TPG_OFS_LINE_PD_LO 8'h0D
`define TPG_OFS_BACK_PORCH 8'h0E
`define TPG_OFS_FRONT_PORCH 8'h0F
`define TPG_OFS_COLOR_ZERO 8'h10
`define TPG_OFS_COLOR_ONE 8'h11

// Line period tick and default line time (31.75 us)
`define TPG_TICK_NS 32'h0000_000A
`define TPG_LINE_TIME_NS 32'h0000_7C06
`define TPG_LINE_PD_RESET (`TPG_LINE_TIME_NS / `TPG_TICK_NS)

// Reset values
`define TPG_RST_LINE_PD_HI 8'h0C
`define TPG_RST_LINE_PD_LO (`TPG_LINE_PD_RESET & 32'h0000_00FF)
`define TPG_RST_BACK_PORCH 8'h21
`define TPG_RST_FRONT_PORCH 8'h0A
`define TPG_RST_COLOR_ZERO 8'hAA
`define TPG_RST_COLOR_ONE 8'h33

// Clock period 25 ns in ps; the timer counts half ticks (5 ns)
`define TPG_CLK_PS 32'h0000_61A8
`define TPG_HALF_TICKS_PER_CLK ((`TPG_CLK_PS * 32'h2) / (`TPG_TICK_NS * 32'h3E8))

// Pattern configuration byte fields
`define TPG_CFG_FIXED_BIT 7
`define TPG_CFG_BARS_HI 5
`define TPG_CFG_BARS_LO 4
`define TPG_CFG_CHUNK_HI 3
`define TPG_CFG_CHUNK_LO 0

`endif

// [rtl/tpg_line_timing.sv]
// Test-pattern line timing, vertical porches and color registers
//
// Function
// [R01] Line period: 16 bits of 10 ns ticks
// [R02] Reset line period is 31.75 us
// [R03] Back porch blank lines follow frame start
// [R04] Front porch blank lines precede frame end
// [R05] Bar 0 and bar 1 use color registers
// [R06] Fixed pattern bytes one, two from colors
// [R07] Porch lines are blank, carry no video
// [R08] Bit 7 picks bars or fixed pattern
// [R09] Bar code selects 1, 2, 4, 8 bars
// [R10] Chunk length 1 to 15 bytes
// [R11] Total lines include blanking and active lines
// [R12] Every line starts at period expiry
`timescale 1ns/1ps
`default_nettype none
`include "tpg_defs.svh"

module tpg_line_timing (
    input wire logic i_ref_clk, // 40 MHz system clock
    input wire logic i_rst, // Synchronous reset, active high
    input wire logic [7:0] i_reg_page, // Indirect page select
    input wire logic [7:0] i_reg_addr, // Register offset in page
    input wire logic i_reg_wr, // Write strobe
    input wire logic [7:0] i_reg_wdata, // Write data
    input wire logic i_reg_rd, // Read strobe
    output logic [7:0] o_reg_rdata, // Read data, next cycle
    output logic o_reg_rvalid, // Read data valid pulse
    input wire logic i_gen_enable, // Generator on
    input wire tpg_pkg::tpg_pattern_cfg_t i_pattern_cfg, // Pattern select
    input wire logic [15:0] i_frame_active_line_count, // Active lines
    input wire logic [15:0] i_frame_total_line_count, // Total lines
    input wire logic [15:0] i_line_size, // Active bytes per line
    input wire logic [15:0] i_bar_size, // Bytes per bar
    input wire logic [12:0][7:0] i_upper_colors, // Color bytes 2 to 14
    output tpg_pkg::tpg_frame_flags_t o_frame_flags, // Frame events
    output logic [15:0] o_line_index, // Line within frame
    output logic o_byte_valid, // Pattern byte valid
    output logic [7:0] o_byte_data // Pattern byte
);

    logic [7:0] line_pd_hi_q;
    logic [7:0] line_pd_lo_q;
    logic [7:0] back_porch_line_count_q;
    logic [7:0] front_porch_line_count_q;
    logic [7:0] color_value_zero_q;
    logic [7:0] color_value_one_q;

    logic page_hit;
    logic [15:0] line_period_ticks;
    logic line_tick;

    tpg_pkg::tpg_state_t state_q;
    tpg_pkg::tpg_state_t state_d;
    logic [15:0] line_idx_q;
    logic [15:0] line_idx_d;
    logic [16:0] active_begin;
    logic [16:0] front_begin;
    logic [16:0] tail_begin;
    logic [16:0] frame_len;
    logic [16:0] next_line;
    logic stay_idle;
    logic active_start;

    logic [14:0][7:0] colors;

    // Register access
    assign page_hit = (i_reg_page == `TPG_PAGE);
    assign line_period_ticks = {line_pd_hi_q, line_pd_lo_q}; // [R01]

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            line_pd_hi_q <= `TPG_RST_LINE_PD_HI; // [R02]
            line_pd_lo_q <= 8'(`TPG_RST_LINE_PD_LO); // [R02]
            back_porch_line_count_q <= `TPG_RST_BACK_PORCH; // [R03]
            front_porch_line_count_q <= `TPG_RST_FRONT_PORCH; // [R04]
            color_value_zero_q <= `TPG_RST_COLOR_ZERO; // [R05]
            color_value_one_q <= `TPG_RST_COLOR_ONE; // [R05]
        end
        else if (i_reg_wr && page_hit)
        begin
            case (i_reg_addr)
                `TPG_OFS_LINE_PD_HI: line_pd_hi_q <= i_reg_wdata;
                `TPG_OFS_LINE_PD_LO: line_pd_lo_q <= i_reg_wdata;
                `TPG_OFS_BACK_PORCH: back_porch_line_count_q <= i_reg_wdata;
                `TPG_OFS_FRONT_PORCH: front_porch_line_count_q <= i_reg_wdata;
                `TPG_OFS_COLOR_ZERO: color_value_zero_q <= i_reg_wdata;
                `TPG_OFS_COLOR_ONE: color_value_one_q <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    // Read data registered; other offsets read zero
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end
        else
        begin
            o_reg_rvalid <= i_reg_rd;
            o_reg_rdata <= 8'h00;
            if (i_reg_rd && page_hit)
            begin
                case (i_reg_addr)
                    `TPG_OFS_LINE_PD_HI: o_reg_rdata <= line_pd_hi_q;
                    `TPG_OFS_LINE_PD_LO: o_reg_rdata <= line_pd_lo_q;
                    `TPG_OFS_BACK_PORCH: o_reg_rdata <= back_porch_line_count_q;
                    `TPG_OFS_FRONT_PORCH:
                        o_reg_rdata <= front_porch_line_count_q;
                    `TPG_OFS_COLOR_ZERO: o_reg_rdata <= color_value_zero_q;
                    `TPG_OFS_COLOR_ONE: o_reg_rdata <= color_value_one_q;
                    default: o_reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    tpg_period_timer u_timer (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_line_period_ticks(line_period_ticks),
        .o_expire(line_tick)
    );

    // Frame layout: FS, back porch, active, front porch, FE, remaining blank
    always_comb
    begin
        active_begin = {9'h000, back_porch_line_count_q};
        front_begin = active_begin + {1'b0, i_frame_active_line_count};
        tail_begin = front_begin + {9'h000, front_porch_line_count_q};
        // Frame is never shorter than its blanking plus active lines
        frame_len = {1'b0, i_frame_total_line_count}; // [R11]
        if (frame_len < tail_begin + 17'h00001)
        begin
            frame_len = tail_begin + 17'h00001;
        end
        if (state_q == tpg_pkg::TPG_ST_IDLE)
        begin
            next_line = 17'h00000;
        end
        else if ({1'b0, line_idx_q} + 17'h00001 >= frame_len)
        begin
            next_line = 17'h00000;
        end
        else
        begin
            next_line = {1'b0, line_idx_q} + 17'h00001;
        end
        // New frame only starts while enabled
        stay_idle = (next_line == 17'h00000) && !i_gen_enable;
        line_idx_d = next_line[15:0];
        state_d = state_q;
        if (stay_idle)
        begin
            state_d = tpg_pkg::TPG_ST_IDLE;
        end
        else if (next_line < active_begin)
        begin
            state_d = tpg_pkg::TPG_ST_BACK; // [R03] [R07]
        end
        else if (next_line < front_begin)
        begin
            state_d = tpg_pkg::TPG_ST_ACTIVE;
        end
        else if (next_line < tail_begin)
        begin
            state_d = tpg_pkg::TPG_ST_FRONT; // [R04] [R07]
        end
        else
        begin
            state_d = tpg_pkg::TPG_ST_TAIL;
        end
        active_start = line_tick && (state_d == tpg_pkg::TPG_ST_ACTIVE);
    end

    // Line sequencer advances only on period expiry
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            state_q <= tpg_pkg::TPG_ST_IDLE;
            line_idx_q <= 16'h0000;
        end
        else if (line_tick) // [R12]
        begin
            state_q <= state_d;
            line_idx_q <= line_idx_d;
        end
    end

    // Event pulses and line levels
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_frame_flags <= '0;
            o_line_index <= 16'h0000;
        end
        else
        begin
            o_frame_flags.frame_start <= 1'b0;
            o_frame_flags.frame_end <= 1'b0;
            o_frame_flags.line_start <= 1'b0;
            if (line_tick)
            begin
                o_line_index <= line_idx_d;
                o_frame_flags.line_start <= !stay_idle; // [R12]
                o_frame_flags.frame_start <= !stay_idle
                    && (next_line == 17'h00000); // [R03]
                o_frame_flags.frame_end <= !stay_idle
                    && (next_line == tail_begin); // [R04]
                o_frame_flags.line_active <=
                    (state_d == tpg_pkg::TPG_ST_ACTIVE);
                o_frame_flags.line_blank <= !stay_idle
                    && (state_d != tpg_pkg::TPG_ST_ACTIVE); // [R07]
            end
        end
    end

    assign colors = {i_upper_colors, color_value_one_q, color_value_zero_q};

    tpg_byte_pattern u_pattern (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_line_start(active_start),
        .i_line_size(i_line_size),
        .i_bar_size(i_bar_size),
        .i_cfg(i_pattern_cfg),
        .i_colors(colors),
        .o_valid(o_byte_valid),
        .o_data(o_byte_data)
    );

endmodule : tpg_line_timing
`default_nettype wire

// [rtl/tpg_period_timer.sv]
// Line period timer counting 5 ns half ticks on the 25 ns clock
`timescale 1ns/1ps
`default_nettype none
`include "tpg_defs.svh"

module tpg_period_timer (
    input wire logic i_ref_clk, // System clock
    input wire logic i_rst, // Synchronous reset
    input wire logic [15:0] i_line_period_ticks, // Period in 10 ns ticks
    output logic o_expire // One-cycle line boundary pulse
);

    localparam logic [17:0] STEP = 18'(`TPG_HALF_TICKS_PER_CLK);

    logic [17:0] acc_q;
    logic [17:0] acc_sum;
    logic [17:0] target;

    // Zero period behaves as one tick
    always_comb
    begin
        target = {1'b0, i_line_period_ticks, 1'b0};
        if (i_line_period_ticks == 16'h0000)
        begin
            target = 18'h00002;
        end
        acc_sum = acc_q + STEP;
    end

    // Remainder carried so the mean period is exact in 10 ns units
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            acc_q <= 18'h00000;
            o_expire <= 1'b0;
        end
        else if (acc_sum >= target)
        begin
            acc_q <= acc_sum - target; // [R01] [R12]
            o_expire <= 1'b1;
        end
        else
        begin
            acc_q <= acc_sum;
            o_expire <= 1'b0;
        end
    end

endmodule : tpg_period_timer
`default_nettype wire

// [rtl/tpg_pkg.sv]
// Types shared by the test-pattern timing slice
package tpg_pkg;

    typedef enum logic [4:0] {
        TPG_ST_IDLE = 5'h01,
        TPG_ST_BACK = 5'h02,
        TPG_ST_ACTIVE = 5'h04,
        TPG_ST_FRONT = 5'h08,
        TPG_ST_TAIL = 5'h10
    } tpg_state_t;

    // Pattern select byte
    typedef struct packed {
        logic fixed_pattern_select;
        logic reserved;
        logic [1:0] bar_count_code;
        logic [3:0] chunk_len;
    } tpg_pattern_cfg_t;

    // Frame and line events
    typedef struct packed {
        logic frame_start;
        logic frame_end;
        logic line_start;
        logic line_active;
        logic line_blank;
    } tpg_frame_flags_t;

endpackage : tpg_pkg

// [test/testbench.sv]
// Self-checking bench of the test-pattern timing slice
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic i_ref_clk, i_rst, i_reg_wr, i_reg_rd, i_gen_enable, rvalid, bval;
    logic [7:0] i_reg_page, i_reg_addr, i_reg_wdata, rdata, bdat;
    logic [7:0] vbp, vfp, col0, col1;
    logic [15:0] act, tot, lsz, bsz, lidx, sink_bytes, sink_frames;
    logic [12:0][7:0] upc;
    logic act_l, chk;
    tpg_pkg::tpg_pattern_cfg_t cfg;
    tpg_pkg::tpg_frame_flags_t flags;
    logic [7:0] rq[$];
    logic [7:0] bq[$];
    logic [7:0] rst_v [6] = '{8'h0C, 8'h67, 8'h21, 8'h0A, 8'hAA, 8'h33};
    logic [7:0] wv [6];
    int mismatches, check_count, cyc, lines, nexp, exp_len, n;

    tpg_line_timing tpg_line_timing_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_reg_page(i_reg_page), .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_gen_enable(i_gen_enable), .i_pattern_cfg(cfg),
        .i_frame_active_line_count(act), .i_frame_total_line_count(tot),
        .i_line_size(lsz), .i_bar_size(bsz), .i_upper_colors(upc),
        .o_frame_flags(flags), .o_line_index(lidx), .o_byte_valid(bval),
        .o_byte_data(bdat));

    tpg_csi_sink tpg_csi_sink_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_flags(flags), .i_valid(bval), .o_byte_total(sink_bytes),
        .o_frame_total(sink_frames));

    initial
    begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end

    task check_byte(input string nm, input logic [7:0] e, g);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : check_byte

    task check_word(input string nm, input logic [15:0] e, g);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : check_word

    task summarize;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    // Read: d is the expected answer, queued for the watcher
    task reg_op(input logic [7:0] pg, a, d, input logic w, r);
        @(posedge i_ref_clk);
        i_reg_page <= pg;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= w;
        i_reg_rd <= r;
        if (r)
            rq.push_back(d);
        @(posedge i_ref_clk);
        i_reg_wr <= 1'b0;
        i_reg_rd <= 1'b0;
    endtask : reg_op

    // Clocks between two line starts
    task span;
        while (!flags.line_start)
            @(posedge i_ref_clk);
        n = 0;
        do
        begin
            @(posedge i_ref_clk);
            n++;
        end
        while (!flags.line_start);
    endtask : span

    function automatic logic [7:0] pix(input int k);
        int b;
        int nb;
        nb = 1 << cfg.bar_count_code;
        b = (bsz == 16'h0000) ? 0 : k / bsz;
        b = (b < nb) ? b : nb - 1;
        if (cfg.fixed_pattern_select)
            b = k % ((cfg.chunk_len == 4'h0) ? 1 : cfg.chunk_len);
        return (b == 0) ? col0 : (b == 1) ? col1 : upc[b - 2];
    endfunction : pix

    always @(posedge i_ref_clk)
    begin
        if (chk && flags.line_start)
        begin
            act_l = lidx >= vbp && lidx < vbp + act;
            check_byte("active", {7'h00, act_l}, {7'h00, flags.line_active});
            check_byte("blank", {7'h00, !act_l}, {7'h00, flags.line_blank});
            check_byte("frame end", {7'h00, lidx == vbp + act + vfp},
                {7'h00, flags.frame_end});
            if (flags.frame_start && lines > 0)
                check_word("frame lines", 16'(exp_len), 16'(lines));
            lines = flags.frame_start ? 1 : lines + 1;
            for (int k = 0; k < (act_l ? int'(lsz) : 0); k++)
                bq.push_back(pix(k));
            nexp += act_l ? int'(lsz) : 0;
        end
        if (bval)
            check_byte("pattern byte", bq.size() ? bq.pop_front() : 8'hXX, bdat);
        if (rvalid)
            check_byte("read data", rq.size() ? rq.pop_front() : 8'hXX, rdata);
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            summarize();
        end
    end

    initial
    begin
        n = $urandom(10856);
        {i_rst, i_reg_wr, i_reg_rd, i_gen_enable, chk} = 5'h10;
        {i_reg_page, i_reg_addr, i_reg_wdata} = 24'h000000;
        cfg = 8'h00;
        upc = '0;
        act = 16'(1 + $urandom % 4);
        vbp = 8'(1 + $urandom % 3);
        vfp = 8'($urandom % 3);
        tot = 16'(vbp + act + vfp - 1 + $urandom % 4);
        lsz = 16'(4 + $urandom % 9);
        bsz = 16'($urandom % 5);
        repeat (8) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        for (int k = 0; k < 6; k++)
            reg_op(8'h00, 8'h0C + 8'(k), rst_v[k], 1'b0, 1'b1);
        reg_op(8'h00, 8'h12, 8'h00, 1'b0, 1'b1);
        reg_op(8'h01, 8'h0E, 8'h55, 1'b1, 1'b0);
        reg_op(8'h01, 8'h0E, 8'h00, 1'b0, 1'b1);
        reg_op(8'h00, 8'h0E, 8'h21, 1'b0, 1'b1);
        i_gen_enable <= 1'b1;
        span();
        check_word("default period", 16'd1270, 16'(n));
        i_rst <= 1'b1;
        i_gen_enable <= 1'b0;
        repeat (8) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        col0 = 8'($urandom);
        col1 = 8'($urandom);
        wv = '{8'h00, 8'h28, vbp, vfp, col0, col1};
        for (int k = 0; k < 6; k++)
        begin
            reg_op(8'h00, 8'h0C + 8'(k), wv[k], 1'b1, 1'b0);
            reg_op(8'h00, 8'h0C + 8'(k), wv[k], 1'b0, 1'b1);
        end
        exp_len = (tot > vbp + act + vfp) ? tot : vbp + act + vfp + 1;
        chk = 1'b1;
        i_gen_enable <= 1'b1;
        span();
        check_word("line period", 16'd16, 16'(n));
        for (int f = 0; f < 8; f++)
        begin
            while (!flags.frame_end)
                @(posedge i_ref_clk);
            cfg <= {f[2], 1'b0, f[1:0], 4'(1 + $urandom % 15)};
            for (int k = 0; k < 13; k++)
                upc[k] <= 8'($urandom);
            @(posedge i_ref_clk);
        end
        check_word("frames seen", 16'd8, sink_frames);
        check_word("bytes seen", 16'(nexp), sink_bytes);
        check_word("bytes left", 16'h0000, 16'(bq.size()));
        summarize();
    end
endmodule : testbench

bind tpg_line_timing tpg_line_timing_properties tpg_line_timing_properties_i (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_rd(i_reg_rd),
    .o_reg_rvalid(o_reg_rvalid), .o_reg_rdata(o_reg_rdata),
    .o_frame_flags(o_frame_flags), .o_line_index(o_line_index),
    .o_byte_valid(o_byte_valid));

`default_nettype wire

// [test/tpg_csi_sink.sv]
// Receiving end of the pattern stream: counts bytes and closed frames
`timescale 1ns/1ps
`default_nettype none

module tpg_csi_sink (
    input wire logic i_ref_clk, // Clock
    input wire logic i_rst, // Reset
    input wire tpg_pkg::tpg_frame_flags_t i_flags, // Frame events
    input wire logic i_valid, // Byte valid
    output logic [15:0] o_byte_total, // Bytes taken
    output logic [15:0] o_frame_total // Frames closed
);
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_byte_total <= 16'h0000;
            o_frame_total <= 16'h0000;
        end
        else
        begin
            o_byte_total <= o_byte_total + {15'h0000, i_valid};
            o_frame_total <= o_frame_total + {15'h0000, i_flags.frame_end};
        end
    end
endmodule : tpg_csi_sink

`default_nettype wire

// [test/tpg_line_timing_properties.sv]
// Port assertions of the test-pattern timing slice
`timescale 1ns/1ps
`default_nettype none

module tpg_line_timing_properties (
    input wire logic i_ref_clk, // Clock
    input wire logic i_rst, // Reset
    input wire logic i_reg_rd, // Read strobe
    input wire logic o_reg_rvalid, // Read valid
    input wire logic [7:0] o_reg_rdata, // Read data
    input wire tpg_pkg::tpg_frame_flags_t o_frame_flags, // Events
    input wire logic [15:0] o_line_index, // Line index
    input wire logic o_byte_valid // Byte valid
);
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read strobe got no answer");
    a_read_quiet: assert property (!i_reg_rd |=> !o_reg_rvalid)
        else $error("answer without read strobe");
    a_rdata_idle_zero: assert property (!o_reg_rvalid |-> o_reg_rdata == 8'h00)
        else $error("read data not zero while idle");
    a_start_line_zero: assert property (o_frame_flags.frame_start |->
        o_frame_flags.line_start && o_line_index == 16'h0000)
        else $error("frame start not on line zero");
    a_end_blank_line: assert property (o_frame_flags.frame_end |->
        o_frame_flags.line_start && o_frame_flags.line_blank)
        else $error("frame end not on a blank line");
    a_line_kind_excl: assert property (o_frame_flags.line_start |->
        o_frame_flags.line_active != o_frame_flags.line_blank)
        else $error("line neither or both active and blank");
    a_line_pulse_once: assert property (o_frame_flags.line_start |=>
        !o_frame_flags.line_start [*2])
        else $error("line start longer than one cycle");
    a_index_steps: assert property (
        o_frame_flags.line_start && !o_frame_flags.frame_start |->
        o_line_index == $past(o_line_index) + 16'h0001)
        else $error("line index did not step by one");
    a_bytes_active: assert property ($rose(o_byte_valid) |->
        o_frame_flags.line_active)
        else $error("byte stream began outside an active line");

    c_frame_end: cover property (o_frame_flags.frame_end);
    c_byte_start: cover property ($rose(o_byte_valid));
    c_read: cover property (o_reg_rvalid);
endmodule : tpg_line_timing_properties

`default_nettype wire
